/* logic/vtsc_host.sv */
// Host that drives transfer, split and serial cycles of a video memory.
`timescale 1ns/10ps
module vtsc_host
    import vtsc_pkg::*;
(
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] haddr,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Memory pins.
    output vtsc_pins_t       pins,
    input  wire logic [7:0]  sioIn,
    input  wire logic        splitHalfFlag
);
    typedef enum logic [3:0] {
        ST_IDLE   = 4'h0,
        ST_SETUP  = 4'h1,
        ST_CBRCAS = 4'h2,
        ST_RASLO  = 4'h3,
        ST_COLPH  = 4'h4,
        ST_DTRISE = 4'h5,
        ST_RASHI  = 4'h6,
        ST_SCHI   = 4'h7,
        ST_SCLO   = 4'h8
    } vtsc_state_t;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [8:0] pinSync;
    vtsc_sync #(.WIDTH(9)) u_sync (
        .sys_clk (sys_clk),
        .asyncIn ({splitHalfFlag, sioIn}),
        .syncOut (pinSync)
    );

    // True when the offset sits on the last column of a stop segment.
    function automatic logic isBoundary(logic [7:0] col, logic [3:0] code);
        logic [7:0] segMask;
        segMask = 8'(({8'h00, 8'hff} >> (4'h8 - code)));
        return (col & segMask) == segMask;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    vtsc_state_t state_q, state_d;
    vtsc_cmd_t   cmd_q, cmd_d;
    vtsc_pins_t  pins_q, pins_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [24:0] addr_q, addr_d;
    logic [7:0]  mask_q, mask_d, wrData_q, wrData_d, rdData_q, rdData_d;
    logic        persist_q, persist_d, boundOn_q, boundOn_d;
    logic [3:0]  bound_q, bound_d;
    logic        started_q, started_d, dirOut_q, dirOut_d;
    logic        refused_q, refused_d, haveRead_q, haveRead_d;
    logic        readMsb_q, readMsb_d;
    logic        aphWr_q, aphWr_d, hrdy_q, hrdy_d;
    logic [7:0]  aphAddr_q, aphAddr_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic        aphValid, wrCtrl, refuse, isWriteXfer, isSplit;
    vtsc_cmd_t   newCmd;

    assign aphValid = hsel && htrans[1] && hready;
    assign wrCtrl   = aphWr_q && (aphAddr_q == REG_CTRL) && hwdata[CTRL_GO];
    assign newCmd   = vtsc_cmd_t'(hwdata[3:0]);
    assign isWriteXfer = (cmd_q == CMD_MWRITE_XFER) ||
                         (cmd_q == CMD_SPLIT_WRITE);
    assign isSplit  = (cmd_q == CMD_SPLIT_READ) || (cmd_q == CMD_SPLIT_WRITE);

    // Screening of a started command against the host-side obligations.
    always_comb begin
        refuse = state_q != ST_IDLE;
        if (newCmd == CMD_SERIAL && !started_q) begin
            refuse = 1'b1;
        end
        if ((newCmd == CMD_MWRITE_XFER || newCmd == CMD_SPLIT_WRITE) &&
            haveRead_q && addr_q[8] != readMsb_q) begin
            refuse = 1'b1;
        end
        if ((newCmd == CMD_SPLIT_READ || newCmd == CMD_SPLIT_WRITE) &&
            boundOn_q && isBoundary(addr_q[ADDR_COL_LSB +: 8], bound_q)) begin
            refuse = 1'b1;
        end
        if (newCmd > CMD_SERIAL) begin
            refuse = 1'b1;
        end
    end

    // ****************************************************************
    // Bus slave next state
    // ****************************************************************
    // Read data are fixed in the address phase so that the slave never
    // needs wait states; a read shows state as of that phase.
    always_comb begin
        aphWr_d   = aphValid && hwrite;
        aphAddr_d = aphValid ? haddr[7:0] : aphAddr_q;
        hrdy_d    = 1'b1;
        hrdata_d  = hrdata_q;
        if (aphValid && !hwrite) begin
            unique case (haddr[7:0])
                REG_CTRL:   hrdata_d = {28'h0000000, cmd_q};
                REG_ADDR:   hrdata_d = {7'h00, addr_q};
                REG_MASK:   hrdata_d = {23'h000000, persist_q, mask_q};
                REG_SDATA:  hrdata_d = {24'h000000, rdData_q};
                REG_STATUS: hrdata_d = {26'h0000000, readMsb_q, pinSync[8],
                                        refused_q, dirOut_q, started_q,
                                        state_q != ST_IDLE};
                REG_BOUND:  hrdata_d = {27'h0000000, boundOn_q, bound_q};
                default:    hrdata_d = 32'h00000000;
            endcase
        end
    end

    // ****************************************************************
    // Cycle sequencer next state
    // ****************************************************************
    always_comb begin
        state_d   = state_q;
        cmd_d     = cmd_q;
        pins_d    = pins_q;
        cnt_d     = (cnt_q == 4'h0) ? 4'h0 : cnt_q - 4'h1;
        addr_d    = addr_q;
        mask_d    = mask_q;
        wrData_d  = wrData_q;
        rdData_d  = rdData_q;
        persist_d = persist_q;
        boundOn_d = boundOn_q;
        bound_d   = bound_q;
        started_d = started_q;
        dirOut_d  = dirOut_q;
        refused_d = refused_q;
        haveRead_d = haveRead_q;
        readMsb_d = readMsb_q;
        // Register writes land in the data phase.
        if (aphWr_q) begin
            unique case (aphAddr_q)
                REG_ADDR: addr_d = hwdata[24:0];
                REG_MASK: begin
                    mask_d    = hwdata[7:0];
                    persist_d = hwdata[MASK_PERSIST];
                end
                REG_SDATA: wrData_d = hwdata[7:0];
                REG_BOUND: begin
                    bound_d   = hwdata[3:0];
                    boundOn_d = hwdata[BOUND_ON];
                end
                // Writing one clears the sticky refusal flag.
                REG_STATUS: if (hwdata[ST_REFUSED]) refused_d = 1'b0;
                default: ;
            endcase
        end
        // A refusal in the same cycle as its clear still wins.
        if (wrCtrl && refuse) begin
            refused_d = 1'b1;
        end
        unique case (state_q)
            ST_IDLE: begin
                pins_d = PINS_IDLE;
                // Release the serial lines while the device drives them.
                pins_d.sioOeN = 1'b1;
                if (wrCtrl && !refuse) begin
                    cmd_d = newCmd;
                    cnt_d = 4'(PHASE_CYC);
                    state_d = (newCmd == CMD_SERIAL) ? ST_SCHI : ST_SETUP;
                    if (newCmd == CMD_SERIAL) begin
                        cnt_d = 4'(SC_HALF_CYC);
                        pins_d.serialShiftClock  = 1'b1;
                        pins_d.serialPortEnableN = 1'b0;
                        pins_d.sioOut = wrData_q;
                        pins_d.sioOeN = dirOut_q;
                    end
                end
            end
            ST_SETUP: begin
                // Function levels stand before the row strobe falls.
                pins_d.addr = addr_q[8:0];
                pins_d.transferOutputEnableN = cmd_q == CMD_REG_CLEAR;
                pins_d.casN = 1'b1;
                pins_d.weN  = !isWriteXfer;
                pins_d.specialFunctionFlag = isSplit;
                // Per-cycle mask is driven on the data pins.
                pins_d.ioOut = mask_q;
                pins_d.ioOeN = !(isWriteXfer && !persist_q);
                if (cnt_q == 4'h0) begin
                    cnt_d = 4'(PHASE_CYC);
                    if (cmd_q == CMD_REG_CLEAR) begin
                        pins_d.casN = 1'b0;
                        state_d = ST_CBRCAS;
                    end else begin
                        pins_d.rasN = 1'b0;
                        state_d = ST_RASLO;
                    end
                end
            end
            ST_CBRCAS: if (cnt_q == 4'h0) begin
                cnt_d = 4'(PHASE_CYC);
                pins_d.rasN = 1'b0;
                state_d = ST_RASLO;
            end
            ST_RASLO: if (cnt_q == 4'h0) begin
                cnt_d = 4'(PHASE_CYC);
                pins_d.ioOeN = 1'b1;
                if (cmd_q == CMD_REG_CLEAR) begin
                    state_d = ST_RASHI;
                    pins_d.rasN = 1'b1;
                    pins_d.casN = 1'b1;
                end else begin
                    // Column gives the serial start position.
                    pins_d.addr = addr_q[ADDR_COL_LSB +: 9];
                    pins_d.casN = 1'b0;
                    state_d = ST_COLPH;
                end
            end
            ST_COLPH: if (cnt_q == 4'h0) begin
                cnt_d = 4'(PHASE_CYC);
                pins_d.transferOutputEnableN = 1'b1;
                state_d = ST_DTRISE;
            end
            ST_DTRISE: if (cnt_q == 4'h0) begin
                cnt_d = 4'(PHASE_CYC);
                pins_d.rasN = 1'b1;
                pins_d.casN = 1'b1;
                state_d = ST_RASHI;
            end
            ST_RASHI: if (cnt_q == 4'h0) begin
                // Recovery before serial access, so the clock never
                // rises with the row strobe low.
                state_d = ST_IDLE;
                unique case (cmd_q)
                    CMD_READ_XFER: begin
                        started_d  = 1'b1;
                        dirOut_d   = 1'b1;
                        haveRead_d = 1'b1;
                        readMsb_d  = addr_q[8];
                    end
                    CMD_MWRITE_XFER: begin
                        started_d = 1'b1;
                        dirOut_d  = 1'b0;
                    end
                    CMD_SPLIT_READ: begin
                        haveRead_d = 1'b1;
                        readMsb_d  = addr_q[8];
                    end
                    CMD_REG_CLEAR: begin
                        persist_d = 1'b0;
                        boundOn_d = 1'b0;
                        bound_d   = BOUND_RESET;
                    end
                    default: ;
                endcase
            end
            ST_SCHI: if (cnt_q == 4'h0) begin
                cnt_d = 4'(SC_HALF_CYC);
                rdData_d = pinSync[7:0];
                pins_d.serialShiftClock = 1'b0;
                state_d = ST_SCLO;
            end
            ST_SCLO: if (cnt_q == 4'h0) begin
                pins_d = PINS_IDLE;
                state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q <= ST_IDLE;      cmd_q <= CMD_READ_XFER;
            pins_q <= PINS_IDLE;     cnt_q <= 4'h0;
            addr_q <= 25'h0000000;   mask_q <= MASK_RESET;
            wrData_q <= 8'h00;       rdData_q <= 8'h00;
            persist_q <= 1'b0;       boundOn_q <= 1'b0;
            bound_q <= BOUND_RESET;  started_q <= 1'b0;
            dirOut_q <= 1'b0;        refused_q <= 1'b0;
            haveRead_q <= 1'b0;      readMsb_q <= 1'b0;
            aphWr_q <= 1'b0;         aphAddr_q <= 8'h00;
            hrdy_q <= 1'b1;          hrdata_q <= 32'h00000000;
        end else begin
            state_q <= state_d;      cmd_q <= cmd_d;
            pins_q <= pins_d;        cnt_q <= cnt_d;
            addr_q <= addr_d;        mask_q <= mask_d;
            wrData_q <= wrData_d;    rdData_q <= rdData_d;
            persist_q <= persist_d;  boundOn_q <= boundOn_d;
            bound_q <= bound_d;      started_q <= started_d;
            dirOut_q <= dirOut_d;    refused_q <= refused_d;
            haveRead_q <= haveRead_d; readMsb_q <= readMsb_d;
            aphWr_q <= aphWr_d;      aphAddr_q <= aphAddr_d;
            hrdy_q <= hrdy_d;        hrdata_q <= hrdata_d;
        end
    end

    assign pins      = pins_q;
    assign hreadyout = hrdy_q;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    sequence rasFall;
        $fell(pins.rasN);
    endsequence
    sequence shiftClkRise;
        $rose(pins.serialShiftClock);
    endsequence

    AST_READ_CODE: assert property (
        rasFall and cmd_q == CMD_READ_XFER |->
        pins.casN && !pins.transferOutputEnableN && pins.weN &&
        !pins.specialFunctionFlag) else $error("bad read transfer code");
    AST_DT_RISE: assert property (
        rasFall and cmd_q == CMD_READ_XFER |->
        !pins.rasN throughout ##[1:12] $rose(pins.transferOutputEnableN))
        else $error("enable did not rise in read transfer");
    AST_SIO_FREE: assert property (
        shiftClkRise and dirOut_q |-> pins.sioOeN)
        else $error("serial lines driven against device");
    AST_CLK_RAS: assert property (
        shiftClkRise |-> pins.rasN && $past(pins.rasN))
        else $error("serial clock rose with row strobe low");
    AST_MSB: assert property (
        rasFall and isWriteXfer and haveRead_q |->
        pins.addr[8] == readMsb_q) else $error("row top bit mismatch");
    AST_STARTED: assert property (shiftClkRise |-> started_q)
        else $error("serial access before start address set");
    AST_SPLIT_CODE: assert property (
        rasFall and isSplit |->
        pins.casN && !pins.transferOutputEnableN &&
        pins.specialFunctionFlag && pins.weN == (cmd_q == CMD_SPLIT_READ))
        else $error("bad split transfer code");
    AST_MSW_CODE: assert property (
        rasFall and cmd_q == CMD_SPLIT_WRITE |->
        !pins.weN && pins.specialFunctionFlag)
        else $error("bad masked split write code");
    AST_NO_BOUND: assert property (
        $fell(pins.casN) and isSplit and boundOn_q |->
        !isBoundary(pins.addr[7:0], bound_q))
        else $error("split start on boundary");
    AST_CLEAR: assert property (
        rasFall and cmd_q == CMD_REG_CLEAR |->
        ##[1:12] (state_q == ST_IDLE && !persist_q && !boundOn_q &&
        bound_q == BOUND_RESET)) else $error("clear did not reset modes");
endmodule

/* logic/vtsc_pkg.sv */
// Constants, pin carrier and field layout of the video memory transfer host.
// ****************************************************************
// Function
// ****************************************************************
package vtsc_pkg;

    // ****************************************************************
    // Clock and pin timing
    // ****************************************************************
    localparam int CLK_NS       = 25;
    localparam int T_PHASE_NS   = 75;
    localparam int T_SC_HALF_NS = 50;
    localparam int PHASE_CYC    = (T_PHASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SC_HALF_CYC  = (T_SC_HALF_NS + CLK_NS - 1) / CLK_NS;

    // ****************************************************************
    // Register map (byte addresses on the AHB-Lite bus)
    // ****************************************************************
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_MASK   = 8'h08;
    localparam logic [7:0] REG_SDATA  = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_BOUND  = 8'h14;

    // Field positions.
    localparam int CTRL_GO      = 4;
    localparam int ADDR_COL_LSB = 16;
    localparam int MASK_PERSIST = 8;
    localparam int BOUND_ON     = 4;
    localparam int ST_BUSY      = 0;
    localparam int ST_STARTED   = 1;
    localparam int ST_DIR_OUT   = 2;
    localparam int ST_REFUSED   = 3;
    localparam int ST_HALF      = 4;
    localparam int ST_READ_MSB  = 5;

    // Reset values.
    localparam logic [3:0] BOUND_RESET = 4'h8;
    localparam logic [7:0] MASK_RESET  = 8'hff;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [3:0] {
        CMD_READ_XFER   = 4'h0,
        CMD_MWRITE_XFER = 4'h1,
        CMD_SPLIT_READ  = 4'h2,
        CMD_SPLIT_WRITE = 4'h3,
        CMD_REG_CLEAR   = 4'h4,
        CMD_SERIAL      = 4'h5
    } vtsc_cmd_t;

    typedef struct packed {
        logic       rasN;
        logic       casN;
        logic       transferOutputEnableN;
        logic       weN;
        logic       specialFunctionFlag;
        logic [8:0] addr;
        logic [7:0] ioOut;
        logic       ioOeN;
        logic       serialShiftClock;
        logic       serialPortEnableN;
        logic [7:0] sioOut;
        logic       sioOeN;
    } vtsc_pins_t;

    localparam vtsc_pins_t PINS_IDLE = '{
        rasN: 1'b1, casN: 1'b1, transferOutputEnableN: 1'b1, weN: 1'b1,
        specialFunctionFlag: 1'b0, addr: 9'h000, ioOut: 8'h00,
        ioOeN: 1'b1, serialShiftClock: 1'b0, serialPortEnableN: 1'b1,
        sioOut: 8'h00, sioOeN: 1'b1};

endpackage

/* logic/vtsc_sync.sv */
// Two-stage synchroniser for levels arriving from the memory pins.
`timescale 1ns/10ps
module vtsc_sync #(
    parameter int WIDTH = 1
) (
    // Clock.
    input  wire logic             sys_clk,
    // Asynchronous level in, synchronised level out.
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_q;

    // The first stage feeds only the second; nothing else may look at it.
    always_ff @(posedge sys_clk) begin
        meta_q  <= asyncIn;
        syncOut <= meta_q;
    end
endmodule

/* sim/vtsc_mem_model.sv */
// Behavioural model of the video memory on the far side of the host.
`timescale 1ns/10ps
module vtsc_mem_model
    import vtsc_pkg::*;
(
    // Memory pins from the host.
    input  wire vtsc_pins_t pins,
    // Serial data and split-half flag back to the host.
    output logic [7:0]      sioIn,
    output logic            splitHalfFlag
);
    // ****************************************************************
    // Transfer decode and serial pointer
    // ****************************************************************
    logic [8:0] ptr, pendStart;
    logic       xfer, isWr, isSplit, pend, dirOut;
    initial begin
        ptr = 9'h000;
        pend = 1'b0;
        dirOut = 1'b0;
        xfer = 1'b0;
        isWr = 1'b0;
        isSplit = 1'b0;
        pendStart = 9'h000;
        sioIn = 8'h00;
    end
    // The cycle kind is fixed by the levels at the row strobe fall.
    always @(negedge pins.rasN) begin
        xfer = pins.casN && !pins.transferOutputEnableN;
        isWr = !pins.weN;
        isSplit = pins.specialFunctionFlag;
    end
    // Column gives the start; a split aims at the idle half.
    always @(negedge pins.casN) begin
        if (xfer && !pins.rasN && isSplit) begin
            pendStart = {~ptr[8], pins.addr[7:0]};
            pend = 1'b1;
        end else if (xfer && !pins.rasN) begin
            ptr = pins.addr;
        end
    end
    // Only full transfers turn the serial direction round.
    always @(posedge pins.rasN) begin
        if (xfer && !isSplit) begin
            dirOut = !isWr;
        end
        xfer = 1'b0;
    end
    // Serial access; never blocked by a transfer in progress.
    always @(posedge pins.serialShiftClock) begin
        if (dirOut && !pins.serialPortEnableN) begin
            sioIn = ptr[7:0] ^ 8'ha5;
        end else begin
            sioIn = ~sioIn;
        end
        if (ptr[7:0] == 8'hff) begin
            // Default boundary: the last column of a half is the jump
            // point for a pending split start.
            ptr = pend ? pendStart : {~ptr[8], 8'h00};
            pend = 1'b0;
        end else begin
            ptr = ptr + 9'h001;
        end
    end
    // A released line must not keep showing the last byte.
    always @(posedge pins.serialPortEnableN) sioIn = ~sioIn;
    assign splitHalfFlag = ptr[8];
endmodule

/* sim/tb.sv */
// Self-checking bench of the video memory transfer host.
`timescale 1ns/10ps
module tb;
    import vtsc_pkg::*;
    // ****************************************************************
    // Clock, bus and monitors
    // ****************************************************************
    logic        sys_clk, srst, hsel, hwrite, hready, hreadyout;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [7:0]  sioIn, shiftOut;
    logic        splitHalfFlag, shiftOe;
    vtsc_pins_t  pins, atFall;
    int          n_mismatch = 0, n_tests = 0;
    localparam logic [31:0] REF = 32'h1 << ST_REFUSED;
    localparam logic [31:0] DIR = 32'h1 << ST_DIR_OUT;
    assign hready = hreadyout;
    vtsc_host uut(.sys_clk, .srst, .hsel, .htrans, .hwrite, .haddr,
        .hsize, .hwdata, .hready, .hreadyout, .hresp(), .hrdata, .pins,
        .sioIn, .splitHalfFlag);
    vtsc_mem_model mem(.pins, .sioIn, .splitHalfFlag);
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Snapshot at the row strobe fall; serial clock never under a low strobe.
    always @(negedge pins.rasN) atFall = pins;
    always @(posedge pins.serialShiftClock) begin
        shiftOe = pins.sioOeN;
        shiftOut = pins.sioOut;
        chk({31'h0, pins.rasN}, 32'h1);
    end
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // One single-word transfer; the bus may stretch either phase.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        do begin @(posedge sys_clk); k++; end while (!hreadyout && k < 50);
        htrans <= 2'h0; hwdata <= d;
        do begin @(posedge sys_clk); k++; end while (!hreadyout && k < 50);
        r = hrdata;
        if (k >= 50) begin n_mismatch++; wrap_up(); end
    endtask
    task automatic st(input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(r & m, e);
    endtask
    // Start a command and poll busy, with a bound on the wait.
    task automatic go(input logic [3:0] c, input logic [8:0] row,
                      input logic [8:0] col);
        int k;
        bus(1'b1, REG_ADDR, (32'(col) << ADDR_COL_LSB) | 32'(row));
        bus(1'b1, REG_CTRL, (32'h1 << CTRL_GO) | 32'(c));
        @(posedge sys_clk);
        k = 0;
        do begin st(32'h0, 32'h0); k++; end while (r[ST_BUSY] && k < 99);
        if (k >= 99) begin n_mismatch++; wrap_up(); end
    endtask
    task automatic refused();
        st(REF, REF);
        bus(1'b1, REG_STATUS, REF);
    endtask
    task automatic fn(input logic [3:0] e);
        chk({28'h0, atFall.casN, atFall.transferOutputEnableN,
             atFall.weN, atFall.specialFunctionFlag}, {28'h0, e});
    endtask
    // Main sequence.
    initial begin
        srst = 1'b1; hsel = 1'b0; htrans = 2'h0; hwrite = 1'b0;
        haddr = 32'h0; hwdata = 32'h0; hsize = 3'h2;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        chk(32'(pins), 32'(PINS_IDLE));
        bus(1'b0, REG_BOUND, 32'h0);
        chk(r, 32'(BOUND_RESET));
        go(CMD_SERIAL, 9'h000, 9'h000);
        refused();
        go(CMD_READ_XFER, 9'h100, 9'h010);
        fn(4'ha);
        chk(32'(atFall.addr), 32'h100);
        st(DIR | 32'h20, DIR | 32'h20);
        go(CMD_SERIAL, 9'h000, 9'h000);
        chk(32'(shiftOe), 32'h1);
        bus(1'b0, REG_SDATA, 32'h0);
        chk(r, 32'h10 ^ 32'ha5);
        for (int i = 0; i < 239; i++) go(CMD_SERIAL, 9'h000, 9'h000);
        bus(1'b0, REG_SDATA, 32'h0);
        chk(r, 32'hff ^ 32'ha5);
        st(32'h10, 32'h10);
        go(CMD_MWRITE_XFER, 9'h020, 9'h000);
        refused();
        bus(1'b1, REG_MASK, 32'h3c);
        go(CMD_MWRITE_XFER, 9'h120, 9'h000);
        fn(4'h8);
        chk({23'h0, atFall.ioOeN, atFall.ioOut}, 32'h3c);
        st(DIR, 32'h0);
        bus(1'b1, REG_SDATA, 32'h5a);
        go(CMD_SERIAL, 9'h120, 9'h000);
        chk({23'h0, shiftOe, shiftOut}, 32'h5a);
        go(CMD_SPLIT_READ, 9'h120, 9'h004);
        fn(4'hb);
        st(DIR, 32'h0);
        bus(1'b1, REG_MASK, (32'h1 << MASK_PERSIST) | 32'h3c);
        go(CMD_SPLIT_WRITE, 9'h120, 9'h004);
        fn(4'h9);
        chk(32'(atFall.ioOeN), 32'h1);
        bus(1'b1, REG_BOUND, (32'h1 << BOUND_ON) | 32'h8);
        go(CMD_SPLIT_READ, 9'h120, 9'h0ff);
        refused();
        go(CMD_SPLIT_READ, 9'h120, 9'h004);
        st(REF, 32'h0);
        go(CMD_REG_CLEAR, 9'h000, 9'h000);
        fn(4'h6);
        bus(1'b0, REG_BOUND, 32'h0);
        chk(r, 32'(BOUND_RESET));
        wrap_up();
    end
endmodule
